// file: dv/pls_backend_model.sv
// pls_backend_model: back-end application logic feeding the local input side.
// assumes the bench picks the word and enables; both launch 1 ns after each rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module pls_backend_model (
  input  wire logic        sys_clk_i,
  input  wire logic [63:0] word_i,
  input  wire logic [7:0]  be_n_i,
  output var  logic [63:0] l_ad_o,
  output var  logic [7:0]  be_n_o
);
  // same system clock as the bus, no local clock of its own
  always @(posedge sys_clk_i) begin
    l_ad_o <= #1 word_i;
    be_n_o <= #1 be_n_i;
  end
endmodule : pls_backend_model
`default_nettype wire

// file: dv/tb.sv
// tb: self-checking bench for the local-side port, one task per scenario.
// assumes a 100 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pls_pkg::*;
  logic        sys_clk_i, rst_n_i, frame_n_i, irdy_n_i, req64_n_i, ack64_n_i;
  logic        data_load_i, base_xfer_n_i, st_w, st_l, st_h, wide_n;
  logic [63:0] ad_i, core_ad_o, l_ad_in_i, l_data_out_o, addr_o, word;
  logic [7:0]  cbe_n_i, core_cbe_n_o, m_be_n, be_in_n, tbe_n_o;
  logic [3:0]  cmd_o;
  int          errors, compares;

  pls_backend_model u_be (.sys_clk_i(sys_clk_i), .word_i(word), .be_n_i(m_be_n),
    .l_ad_o(l_ad_in_i), .be_n_o(be_in_n));
  pls_local_port #(.BUS64(1'b1)) u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .frame_n_i(frame_n_i), .irdy_n_i(irdy_n_i), .ad_i(ad_i), .cbe_n_i(cbe_n_i),
    .req64_n_i(req64_n_i), .ack64_n_i(ack64_n_i), .data_load_i(data_load_i),
    .base_xfer_n_i(base_xfer_n_i), .core_ad_o(core_ad_o), .core_cbe_n_o(core_cbe_n_o),
    .l_ad_in_i(l_ad_in_i), .master_cmd_byte_enable_input_n_i(be_in_n),
    .l_data_out_o(l_data_out_o), .target_start_address_output_o(addr_o),
    .target_byte_enable_output_n_o(tbe_n_o), .target_bus_command_output_o(cmd_o),
    .target_word_transfer_strobe_n_o(st_w), .target_low_word_transfer_strobe_n_o(st_l),
    .target_high_word_transfer_strobe_n_o(st_h), .target_wide_transaction_flag_n_o(wide_n));

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic t_reset;
    chk("addr", 64'h0, addr_o);
    chk("be", 64'hFF, {56'h0, tbe_n_o});
    chk("wide", 64'h1, {63'h0, wide_n});
    chk("hstb", 64'h1, {63'h0, st_h});
  endtask : t_reset

  task automatic t_dac;
    {frame_n_i, ad_i, cbe_n_i} = {1'b0, 64'h0000_0000_1234_5670, 8'hFD};
    step(PLS_LO_ADDR_LAT);
    chk("dac lo", 64'h1234_5670, {32'h0, addr_o[31:0]});
    {ad_i, cbe_n_i} = {64'h0000_0000_89AB_CDE0, 8'hF6};
    step(PLS_HI_ADDR_LAT - PLS_LO_ADDR_LAT);
    chk("dac addr", 64'h89AB_CDE0_1234_5670, addr_o);
    chk("dac cmd", 64'h6, {60'h0, cmd_o});
    frame_n_i = 1'b1;
    step(1);
  endtask : t_dac

  task automatic t_single(input logic [3:0] c);
    {frame_n_i, ad_i, cbe_n_i} = {1'b0, 64'h5555_0000_A5A5_0004, 4'hF, c};
    step(1);
    chk("sac addr", 64'hA5A5_0004, addr_o);
    chk("sac cmd", {60'h0, c}, {60'h0, cmd_o});
    frame_n_i = 1'b1;
    step(1);
  endtask : t_single

  task automatic t_wide;
    {frame_n_i, req64_n_i, ad_i, cbe_n_i} = {2'b00, 64'h100, 8'hF7};
    step(1);
    {irdy_n_i, ack64_n_i, data_load_i, base_xfer_n_i} = 4'b0010;
    {ad_i, cbe_n_i} = {64'hCAFE_F00D_0BAD_BEEF, 8'h5A};
    step(2);
    chk("data", 64'hCAFE_F00D_0BAD_BEEF, l_data_out_o);
    chk("tbe", 64'h5A, {56'h0, tbe_n_o});
    chk("wide", 64'h0, {63'h0, wide_n});
    chk("strobes", 64'h0, {61'h0, st_w, st_l, st_h});
    {frame_n_i, irdy_n_i, req64_n_i, ack64_n_i, data_load_i} = 5'b11110;
    step(3);
    chk("wide end", 64'h1, {63'h0, wide_n});
    chk("narrow stb", 64'h1, {61'h0, st_w, st_l, st_h});
    base_xfer_n_i = 1'b1;
  endtask : t_wide

  task automatic t_master;
    {word, m_be_n} = {64'h0123_4567_89AB_CDEF, 8'h3C};
    step(3);
    chk("core ad", 64'h0123_4567_89AB_CDEF, core_ad_o);
    chk("core cbe", 64'h3C, {56'h0, core_cbe_n_o});
  endtask : t_master

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  initial begin
    errors = 0;
    compares = 0;
    {rst_n_i, frame_n_i, irdy_n_i, req64_n_i, ack64_n_i} = 5'b01111;
    {data_load_i, base_xfer_n_i, ad_i, cbe_n_i} = {2'b01, 64'h0, 8'hFF};
    {word, m_be_n} = {64'h0, 8'hFF};
    step(6);
    t_reset();
    rst_n_i = 1'b1;
    t_dac();
    for (int i = 0; i < 16; i++) t_single(4'(i));
    t_wide();
    t_master();
    end_of_test();
  end
endmodule : tb
`default_nettype wire

// file: include/pls_pkg.sv
// pls_pkg: constants and types shared by the local-side port of the bus interface core.
// assumes the standard bus command encoding; no clock or reset lives here.
package pls_pkg;

  localparam int unsigned PLS_DW        = 32;
  localparam int unsigned PLS_CW        = 4;
  localparam logic [3:0]  PLS_CMD_DAC   = 4'hD;
  localparam logic [3:0]  PLS_BE_NONE_N = 4'hF;
  localparam logic [31:0] PLS_ZERO_DW   = 32'h0000_0000;
  localparam logic [3:0]  PLS_CMD_RST   = 4'h0;
  // cycles from the frame's first low sample to each address half on the outputs
  localparam int unsigned PLS_LO_ADDR_LAT = 1;
  localparam int unsigned PLS_HI_ADDR_LAT = 2;

  // gray along idle -> data -> idle; only the dual address entry from idle takes a two-bit step
  typedef enum logic [1:0] {
    PLS_IDLE  = 2'b00,
    PLS_ADDR2 = 2'b11,
    PLS_DATA  = 2'b01
  } pls_state_t;

endpackage : pls_pkg

// file: src/pls_local_port.sv
// pls_local_port: local (back-end) side of the bus interface core, target and master paths.
// assumes all bus inputs are sampled versions of the bus pins on the shared system clock,
// and that the core's target control supplies the base transfer strobe.
`timescale 1ns/100ps
`default_nettype none
module pls_local_port
  import pls_pkg::*;
#(
  parameter bit BUS64 = 1'b1
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // sampled bus side
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic [63:0] ad_i,
  input  wire logic [7:0]  cbe_n_i,
  input  wire logic        req64_n_i,
  input  wire logic        ack64_n_i,
  // core control
  input  wire logic        data_load_i,
  input  wire logic        base_xfer_n_i,
  // toward the core's bus drivers
  output logic      [63:0] core_ad_o,
  output logic      [7:0]  core_cbe_n_o,
  // local side
  input  wire logic [63:0] l_ad_in_i,
  input  wire logic [7:0]  master_cmd_byte_enable_input_n_i,
  output logic      [63:0] l_data_out_o,
  output logic      [63:0] target_start_address_output_o,
  output logic      [7:0]  target_byte_enable_output_n_o,
  output logic      [3:0]  target_bus_command_output_o,
  output logic             target_word_transfer_strobe_n_o,
  output logic             target_low_word_transfer_strobe_n_o,
  output logic             target_high_word_transfer_strobe_n_o,
  output logic             target_wide_transaction_flag_n_o
);

  pls_state_t  state_ff;
  logic        frame_prev_n_ff;
  logic        req64_lat_ff;
  logic        wide_ff;
  logic [63:0] data_ff;
  logic [63:0] addr_ff;
  logic [7:0]  be_n_ff;
  logic [3:0]  cmd_ff;
  logic [63:0] core_ad_ff;
  logic [7:0]  core_cbe_n_ff;
  logic        addr_phase;
  logic        txn_end;

  // a new frame is its first low sample after a high one
  assign addr_phase = !frame_n_i && frame_prev_n_ff;
  assign txn_end    = frame_n_i && irdy_n_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      frame_prev_n_ff <= 1'b1;
    end else begin
      frame_prev_n_ff <= frame_n_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= PLS_IDLE;
    end else begin
      case (state_ff)
        PLS_IDLE: begin
          if (addr_phase) begin
            state_ff <= (cbe_n_i[3:0] == PLS_CMD_DAC) ? PLS_ADDR2 : PLS_DATA;
          end
        end
        PLS_ADDR2: state_ff <= PLS_DATA;
        PLS_DATA: begin
          // a back-to-back frame restarts address capture without passing idle
          if (addr_phase) begin
            state_ff <= (cbe_n_i[3:0] == PLS_CMD_DAC) ? PLS_ADDR2 : PLS_DATA;
          end else if (txn_end) begin
            state_ff <= PLS_IDLE;
          end
        end
        default: state_ff <= PLS_IDLE;
      endcase
    end
  end

  // address and command capture
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      addr_ff <= {PLS_ZERO_DW, PLS_ZERO_DW};
      cmd_ff  <= PLS_CMD_RST;
    end else if (addr_phase) begin
      addr_ff[31:0]  <= ad_i[31:0];
      addr_ff[63:32] <= PLS_ZERO_DW;
      cmd_ff         <= cbe_n_i[3:0];
    end else if (state_ff == PLS_ADDR2) begin
      // dual address: low half came first, high half now; real command is in this phase
      addr_ff[63:32] <= ad_i[31:0];
      cmd_ff         <= cbe_n_i[3:0];
    end
  end

  // 64-bit negotiation: request latched at address time, confirmed by acknowledge
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      req64_lat_ff <= 1'b0;
      wide_ff      <= 1'b0;
    end else begin
      if (addr_phase) begin
        req64_lat_ff <= BUS64 && !req64_n_i;
      end else if (txn_end) begin
        req64_lat_ff <= 1'b0;
      end
      wide_ff <= req64_lat_ff && !ack64_n_i && !txn_end;
    end
  end

  // byte enables and data toward the local side
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      be_n_ff <= {PLS_BE_NONE_N, PLS_BE_NONE_N};
      data_ff <= {PLS_ZERO_DW, PLS_ZERO_DW};
    end else begin
      if (state_ff == PLS_DATA && !irdy_n_i) begin
        be_n_ff[3:0] <= cbe_n_i[3:0];
        be_n_ff[7:4] <= (BUS64 && wide_ff) ? cbe_n_i[7:4] : PLS_BE_NONE_N;
      end
      if (data_load_i) begin
        data_ff[31:0] <= ad_i[31:0];
        // the upper word only moves when the transfer really is 64 bits wide
        if (BUS64 && wide_ff) begin
          data_ff[63:32] <= ad_i[63:32];
        end
      end
    end
  end

  // master/target-read path: registered to cut the local logic from the bus drivers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      core_ad_ff    <= {PLS_ZERO_DW, PLS_ZERO_DW};
      core_cbe_n_ff <= {PLS_BE_NONE_N, PLS_BE_NONE_N};
    end else begin
      core_ad_ff[31:0]   <= l_ad_in_i[31:0];
      core_ad_ff[63:32]  <= BUS64 ? l_ad_in_i[63:32] : PLS_ZERO_DW;
      core_cbe_n_ff[3:0] <= master_cmd_byte_enable_input_n_i[3:0];
      core_cbe_n_ff[7:4] <= BUS64 ? master_cmd_byte_enable_input_n_i[7:4] : PLS_BE_NONE_N;
    end
  end

  assign core_ad_o                     = core_ad_ff;
  assign core_cbe_n_o                  = core_cbe_n_ff;
  assign l_data_out_o                  = data_ff;
  assign target_start_address_output_o = addr_ff;
  assign target_byte_enable_output_n_o = be_n_ff;
  assign target_bus_command_output_o   = cmd_ff;
  assign target_wide_transaction_flag_n_o = !wide_ff;

  // strobes are handshake outputs and follow the base strobe in the same cycle, the high-word one only in a wide transfer
  assign target_word_transfer_strobe_n_o      = base_xfer_n_i;
  assign target_low_word_transfer_strobe_n_o  = base_xfer_n_i;
  assign target_high_word_transfer_strobe_n_o = base_xfer_n_i ||
                                                !(BUS64 && wide_ff);

  sequence s_frame_start;
    frame_prev_n_ff && !frame_n_i;
  endsequence

  sequence s_dac_start;
    s_frame_start and (cbe_n_i[3:0] == PLS_CMD_DAC);
  endsequence

  a_low_addr_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_frame_start |=> target_start_address_output_o[31:0] == $past(ad_i[31:0]))
    else $error("low start address not captured one clock after frame");

  a_high_addr_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_dac_start ##1 (frame_n_i || !frame_prev_n_ff)
      |=> target_start_address_output_o[63:32] == $past(ad_i[31:0]))
    else $error("high start address not captured two clocks after frame");

  a_sac_high_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_frame_start and (cbe_n_i[3:0] != PLS_CMD_DAC)
      |=> target_start_address_output_o[63:32] == PLS_ZERO_DW)
    else $error("upper address not cleared on single address cycle");

  a_addr_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_ff == PLS_DATA && !addr_phase) |=> $stable(target_start_address_output_o))
    else $error("start address changed inside a transaction");

  a_cmd_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_frame_start and (cbe_n_i[3:0] != PLS_CMD_DAC)
      |=> target_bus_command_output_o == $past(cbe_n_i[3:0]))
    else $error("command not latched from address phase");

  a_low_data_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    data_load_i |=> l_data_out_o[31:0] == $past(ad_i[31:0]))
    else $error("lower data word not passed to local side");

  a_high_strobe_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !wide_ff |-> target_high_word_transfer_strobe_n_o)
    else $error("upper word strobe active outside a wide transfer");

  a_low_strobe_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    target_low_word_transfer_strobe_n_o == target_word_transfer_strobe_n_o)
    else $error("lower word strobe differs from base strobe");

  a_wide_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (req64_lat_ff && !ack64_n_i && !txn_end) |=> !target_wide_transaction_flag_n_o)
    else $error("wide transaction flag missing");

  a_high_be_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (state_ff == PLS_DATA && !irdy_n_i && !wide_ff)
      |=> target_byte_enable_output_n_o[7:4] == PLS_BE_NONE_N)
    else $error("upper byte enables active on narrow transfer");

endmodule : pls_local_port
`default_nettype wire
